//--- srcc_regs.svh
// Constants for the status reporting and common command block
`ifndef SRCC_REGS_SVH
`define SRCC_REGS_SVH

// ==========================================================
// Event status bit positions
`define SRCC_ESR_OPC_BIT 3'h0
`define SRCC_ESR_QYE_BIT 3'h2
`define SRCC_ESR_DDE_BIT 3'h3
`define SRCC_ESR_EXE_BIT 3'h4
`define SRCC_ESR_CME_BIT 3'h5
`define SRCC_ESR_PON_BIT 3'h7
`define SRCC_ESR_USED    8'hBD

// ==========================================================
// Status byte bit positions and masks
`define SRCC_STB_MAV_BIT 3'h4
`define SRCC_STB_ESB_BIT 3'h5
`define SRCC_STB_MSS_BIT 3'h6
`define SRCC_SRE_USED    8'hBF

// ==========================================================
// Reset values
`define SRCC_ESE_RST  16'h0000
`define SRCC_SRE_RST  8'h00
`define SRCC_ESR_RST  8'h00

// ==========================================================
// Identification and operation-complete response fields
`define SRCC_IDN_ZERO 8'h30
`define SRCC_IDN_COMMA 8'h2C
`define SRCC_OPC_CHAR 8'h31

`endif

//--- srcc_pkg.sv
// Types for the status reporting and common command block
package srcc_pkg;

	typedef enum logic [3:0]
	{
		SRCC_CMD_NONE  = 4'h0,
		SRCC_CMD_CLS   = 4'h1,
		SRCC_CMD_ESE   = 4'h2,
		SRCC_CMD_ESEQ  = 4'h3,
		SRCC_CMD_ESRQ  = 4'h4,
		SRCC_CMD_IDNQ  = 4'h5,
		SRCC_CMD_OPC   = 4'h6,
		SRCC_CMD_OPCQ  = 4'h7,
		SRCC_CMD_RST   = 4'h8,
		SRCC_CMD_SRE   = 4'h9,
		SRCC_CMD_SREQ  = 4'hA,
		SRCC_CMD_STBQ  = 4'hB
	} srcc_cmd_e;

	typedef enum logic [1:0]
	{
		SRCC_OPC_IDLE  = 2'h0,
		SRCC_OPC_WATCH = 2'h1,
		SRCC_OPC_QUERY = 2'h2,
		SRCC_OPC_BOTH  = 2'h3
	} srcc_opc_e;

	typedef struct packed
	{
		logic [15:0] event_status_enable;
		logic [7:0]  service_request_enable;
		logic [7:0]  event_status;
		srcc_opc_e   opc_state;
		logic        pon_pending;
		logic        err_clear;
		logic        dflt_load;
		logic [15:0] resp_data;
		logic        resp_valid;
		logic        resp_idn;
		logic [7:0]  stb;
	} srcc_state_s;

endpackage

//--- srcc_status.sv
// Status reporting core behind the IEEE 488.2 common commands
//
// How it works
// - Clear status zeroes error queue and event status save same-cycle QYE/DDE/EXE/CME events, and so status byte bit 5; MAV bit 4 still follows its input.
// - Clear status leaves both enable masks untouched.
// - Clear status ends any operation-complete monitoring in progress.
// - Event enable write stores ones as enabled, zeros as masked.
// - Enabled event bits OR into status byte bit 5.
// - Event enable holds 16 bits; only the low 8 take effect.
// - Event layout OPC0 QYE2 DDE3 EXE4 CME5 PON7; bits 1,6 zero.
// - Event status query returns the register's present value.
// - Monitoring start with nothing pending sets OPC at once.
// - Monitoring start while pending clears OPC; set when all done.
// - Operation-complete query answers ASCII 1 once nothing pending.
// - Reset command pulses the load of all routing defaults.
// - Service request enable write stores ones enabled, zeros masked.
// - Service request enable is 8 bits; bit 6 reads zero.
// - Enabled status byte bits OR into master summary bit 6.
// - Status byte: MAV bit 4, ESB bit 5, MSS bit 6, others zero.
// - Enable mask queries return the stored mask value.
// - Identification answers maker and model fields only, in one 16-bit word.
`timescale 1ns/100ps
`include "srcc_regs.svh"

module srcc_status
#(
	// Arbitrary neutral identity values, one byte per field
	parameter logic [7:0] MAKER_CODE = 8'h4D,
	parameter logic [7:0] MODEL_CODE = 8'h53,
	parameter logic [7:0] REV_CODE   = 8'h41
)
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [3:0]  cmd_in,
	input  wire logic [15:0] cmd_data_in,
	input  wire logic        pending_in,
	input  wire logic        msg_avail_in,
	input  wire logic        qye_event_in,
	input  wire logic        dde_event_in,
	input  wire logic        exe_event_in,
	input  wire logic        cme_event_in,
	output logic [15:0]      resp_data_out,
	output logic             resp_valid_out,
	output logic             resp_idn_out,
	output logic [7:0]       stb_out,
	output logic             err_clear_out,
	output logic             dflt_load_out,
	output logic             srq_out
);

	srcc_pkg::srcc_state_s q;
	srcc_pkg::srcc_state_s d;
	srcc_pkg::srcc_cmd_e   cmd;
	logic [7:0]            ev_set;
	logic [7:0]            esr_next;
	logic                  esb;
	logic                  mss;
	logic [7:0]            stb_low;

	assign cmd = srcc_pkg::srcc_cmd_e'(cmd_in);

	// ==========================================================
	// Combinational next state
	always_comb
	begin
		d = q;
		d.resp_valid = 1'b0;
		d.resp_idn = 1'b0;
		d.err_clear = 1'b0;
		d.dflt_load = 1'b0;

		ev_set = 8'h00;
		ev_set[`SRCC_ESR_QYE_BIT] = qye_event_in;
		ev_set[`SRCC_ESR_DDE_BIT] = dde_event_in;
		ev_set[`SRCC_ESR_EXE_BIT] = exe_event_in;
		ev_set[`SRCC_ESR_CME_BIT] = cme_event_in;
		ev_set[`SRCC_ESR_PON_BIT] = q.pon_pending;
		d.pon_pending = 1'b0;

		// Completion while watching
		// Watch and waiting query are kept apart so one never cancels the other
		if (!pending_in && (q.opc_state == srcc_pkg::SRCC_OPC_WATCH ||
			q.opc_state == srcc_pkg::SRCC_OPC_BOTH))
			ev_set[`SRCC_ESR_OPC_BIT] = 1'b1;

		esr_next = q.event_status;

		if (!pending_in && (q.opc_state == srcc_pkg::SRCC_OPC_QUERY ||
			q.opc_state == srcc_pkg::SRCC_OPC_BOTH))
		begin
			d.resp_data = {8'h00, `SRCC_OPC_CHAR};
			d.resp_valid = 1'b1;
		end
		if (!pending_in)
			d.opc_state = srcc_pkg::SRCC_OPC_IDLE;

		case (cmd)
			srcc_pkg::SRCC_CMD_CLS:
			begin
				esr_next = `SRCC_ESR_RST;
				d.err_clear = 1'b1;
				d.opc_state = srcc_pkg::SRCC_OPC_IDLE;
				ev_set[`SRCC_ESR_OPC_BIT] = 1'b0;
			end
			srcc_pkg::SRCC_CMD_ESE:
				d.event_status_enable = cmd_data_in;
			srcc_pkg::SRCC_CMD_ESEQ:
			begin
				d.resp_data = q.event_status_enable;
				d.resp_valid = 1'b1;
			end
			srcc_pkg::SRCC_CMD_ESRQ:
			begin
				d.resp_data = {8'h00, q.event_status};
				d.resp_valid = 1'b1;
			end
			srcc_pkg::SRCC_CMD_IDNQ:
			begin
				d.resp_data = {MAKER_CODE, MODEL_CODE};
				d.resp_valid = 1'b1;
				d.resp_idn = 1'b1;
			end
			srcc_pkg::SRCC_CMD_OPC:
			begin
				if (pending_in)
				begin
					esr_next[`SRCC_ESR_OPC_BIT] = 1'b0;
					ev_set[`SRCC_ESR_OPC_BIT] = 1'b0;
					if (q.opc_state == srcc_pkg::SRCC_OPC_QUERY ||
						q.opc_state == srcc_pkg::SRCC_OPC_BOTH)
						d.opc_state = srcc_pkg::SRCC_OPC_BOTH;
					else
						d.opc_state = srcc_pkg::SRCC_OPC_WATCH;
				end
				else
				begin
					ev_set[`SRCC_ESR_OPC_BIT] = 1'b1;
					d.opc_state = srcc_pkg::SRCC_OPC_IDLE;
				end
			end
			srcc_pkg::SRCC_CMD_OPCQ:
			begin
				if (pending_in)
				begin
					if (q.opc_state == srcc_pkg::SRCC_OPC_WATCH ||
						q.opc_state == srcc_pkg::SRCC_OPC_BOTH)
						d.opc_state = srcc_pkg::SRCC_OPC_BOTH;
					else
						d.opc_state = srcc_pkg::SRCC_OPC_QUERY;
				end
				else
				begin
					d.resp_data = {8'h00, `SRCC_OPC_CHAR};
					d.resp_valid = 1'b1;
				end
			end
			srcc_pkg::SRCC_CMD_RST:
				d.dflt_load = 1'b1;
			srcc_pkg::SRCC_CMD_SRE:
				d.service_request_enable = cmd_data_in[7:0] & `SRCC_SRE_USED;
			srcc_pkg::SRCC_CMD_SREQ:
			begin
				d.resp_data = {8'h00, q.service_request_enable};
				d.resp_valid = 1'b1;
			end
			srcc_pkg::SRCC_CMD_STBQ:
			begin
				d.resp_data = {8'h00, q.stb};
				d.resp_valid = 1'b1;
			end
			default:
			begin
			end
		endcase

		// Set wins over clear, except clear status drops OPC and power-on events
		if (cmd == srcc_pkg::SRCC_CMD_CLS)
			d.event_status = (ev_set & 8'h7C) & `SRCC_ESR_USED;
		else
			d.event_status = (esr_next | ev_set) & `SRCC_ESR_USED;

		esb = |(d.event_status & d.event_status_enable[7:0]);
		stb_low = 8'h00;
		stb_low[`SRCC_STB_MAV_BIT] = msg_avail_in;
		stb_low[`SRCC_STB_ESB_BIT] = esb;
		mss = |(stb_low & d.service_request_enable & `SRCC_SRE_USED);
		d.stb = stb_low;
		d.stb[`SRCC_STB_MSS_BIT] = mss;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			// Masks only change here or on write
			q.event_status_enable <= `SRCC_ESE_RST;
			q.service_request_enable <= `SRCC_SRE_RST;
			q.event_status <= `SRCC_ESR_RST;
			q.opc_state <= srcc_pkg::SRCC_OPC_IDLE;
			q.pon_pending <= 1'b1;
			q.err_clear <= 1'b0;
			q.dflt_load <= 1'b0;
			q.resp_data <= 16'h0000;
			q.resp_valid <= 1'b0;
			q.resp_idn <= 1'b0;
			q.stb <= 8'h00;
		end
		else
			q <= d;
	end

	// ==========================================================
	// Outputs
	assign resp_data_out = q.resp_data;
	assign resp_valid_out = q.resp_valid;
	assign resp_idn_out = q.resp_idn;
	assign stb_out = q.stb;
	assign err_clear_out = q.err_clear;
	assign dflt_load_out = q.dflt_load;
	assign srq_out = q.stb[`SRCC_STB_MSS_BIT];

endmodule

//--- srcc_checker.sv
// Port checker for the status reporting block
`timescale 1ns/100ps
module srcc_checker
(
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic [3:0]  cmd_in,
	input wire logic [15:0] cmd_data_in,
	input wire logic        pending_in,
	input wire logic        msg_avail_in,
	input wire logic        resp_valid_out,
	input wire logic [7:0]  stb_out,
	input wire logic        err_clear_out,
	input wire logic        dflt_load_out,
	input wire logic        srq_out
);
	// ==========
	// Properties
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_opcq_pend;
		cmd_in == 4'h7 && pending_in;
	endsequence
	sequence s_ese_none;
		cmd_in == 4'h2 && cmd_data_in[7:0] == 8'h00;
	endsequence
	sequence s_sre_none;
		cmd_in == 4'h9 && (cmd_data_in[7:0] & 8'hBF) == 8'h00;
	endsequence
	a_srq_mirror: assert property (srq_out == stb_out[6])
		else $error("srq differs from bit 6");
	a_stb_unused: assert property ((stb_out & 8'h8F) == 8'h00)
		else $error("unused status bit set");
	a_cls_clears: assert property (cmd_in == 4'h1 |=>
		err_clear_out && !stb_out[5]) else $error("clear failed");
	a_query_answers: assert property (
		cmd_in inside {4'h3, 4'h4, 4'h5, 4'hA, 4'hB} |=> resp_valid_out)
		else $error("query unanswered");
	a_rst_defaults: assert property (cmd_in == 4'h8 |=> dflt_load_out)
		else $error("no defaults load");
	a_mav_follows: assert property (!$past(rst_in) |->
		stb_out[4] == $past(msg_avail_in)) else $error("bit 4 stale");
	a_esb_masked: assert property (s_ese_none |=> !stb_out[5])
		else $error("masked summary set");
	a_mss_masked: assert property (s_sre_none |=> !srq_out)
		else $error("masked request set");
	a_opcq_wait: assert property (s_opcq_pend |=> !resp_valid_out)
		else $error("early completion answer");
endmodule

//--- srcc_host.sv
// Host side model: source of pending operations
`timescale 1ns/100ps
module srcc_host
#(
	parameter int LEN = 6
)
(
	input  wire logic clk_in,
	input  wire logic go_in,
	output logic      pending_out
);
	int cnt_q = 0;
	always_ff @(posedge clk_in)
		if (go_in)
			cnt_q <= LEN;
		else if (cnt_q > 0)
			cnt_q <= cnt_q - 1;
	assign pending_out = cnt_q > 0;
endmodule

//--- tb.sv
// Testbench for the status reporting block
`timescale 1ns/100ps
module tb;
	logic        clk_in = 0, rst_in = 1, msg = 0, go = 0;
	logic [3:0]  cmd = 0, ev = 0;
	logic [15:0] dat = 0, rd;
	logic [7:0]  stb;
	logic        rv, ri, ec, dl, srq, pend;
	int          bad_count = 0, n_compared = 0, cyc = 0, n;
	always #50 clk_in = ~clk_in;
	srcc_host #(.LEN(10)) host_u (.clk_in(clk_in), .go_in(go),
		.pending_out(pend));
	srcc_status dut_u (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd),
		.cmd_data_in(dat), .pending_in(pend), .msg_avail_in(msg),
		.qye_event_in(ev[0]), .dde_event_in(ev[1]), .exe_event_in(ev[2]),
		.cme_event_in(ev[3]), .resp_data_out(rd), .resp_valid_out(rv),
		.resp_idn_out(ri), .stb_out(stb), .err_clear_out(ec),
		.dflt_load_out(dl), .srq_out(srq));
	// ==========
	// Tasks
	task stop_test;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [16:0] s, input logic [16:0] e);
		n_compared++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected t=%0t seen %h want %h", $time, s, e);
		end
	endtask
	task cmd_go(input logic [3:0] c, input logic [15:0] d);
		@(negedge clk_in);
		cmd = c;
		dat = d;
		@(negedge clk_in);
		cmd = 4'h0;
	endtask
	task qry(input logic [3:0] c, input logic [15:0] e);
		cmd_go(c, 16'h0000);
		chk({rv, rd}, {1'b1, e});
	endtask
	task kick(input logic [4:0] v);
		@(negedge clk_in);
		{go, ev} = v;
		@(negedge clk_in);
		{go, ev} = 5'h00;
	endtask
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			bad_count++;
			stop_test;
		end
	end
	// ==========
	// Sequence
	initial
	begin
		repeat (10) @(negedge clk_in);
		rst_in = 0;
		qry(4'h4, 16'h0080);
		cmd_go(4'h2, 16'h1200);
		qry(4'h3, 16'h1200);
		cmd_go(4'h2, 16'h0080);
		chk({9'h000, stb}, 17'h00020);
		cmd_go(4'h9, 16'hFFFF);
		qry(4'hA, 16'h00BF);
		chk({8'h00, srq, stb}, 17'h00160);
		cmd_go(4'h1, 16'h0000);
		chk({8'h00, ec, stb}, 17'h00100);
		qry(4'h3, 16'h0080);
		qry(4'hA, 16'h00BF);
		kick(5'h0F);
		qry(4'h4, 16'h003C);
		cmd_go(4'h2, 16'h003C);
		msg = 1;
		@(negedge clk_in);
		chk({9'h000, stb}, 17'h00070);
		msg = 0;
		cmd_go(4'h9, 16'h0040);
		chk({8'h00, srq, stb}, 17'h00020);
		qry(4'hA, 16'h0000);
		cmd_go(4'h1, 16'h0000);
		cmd_go(4'h6, 16'h0000);
		qry(4'h4, 16'h0001);
		cmd_go(4'h1, 16'h0000);
		kick(5'h10);
		cmd_go(4'h6, 16'h0000);
		qry(4'h4, 16'h0000);
		cmd_go(4'h7, 16'h0000);
		chk({16'h0000, rv}, 17'h00000);
		n = 0;
		while (rv !== 1'b1 && n < 20)
		begin
			@(negedge clk_in);
			n++;
		end
		chk({rv, rd}, 17'h10031);
		qry(4'h4, 16'h0001);
		cmd_go(4'h1, 16'h0000);
		kick(5'h10);
		cmd_go(4'h6, 16'h0000);
		cmd_go(4'h1, 16'h0000);
		// Outlast the pending span
		repeat (12) @(negedge clk_in);
		qry(4'h4, 16'h0000);
		cmd_go(4'h8, 16'h0000);
		chk({16'h0000, dl}, 17'h00001);
		qry(4'h5, 16'h4D53);
		chk({16'h0000, ri}, 17'h00001);
		stop_test;
	end
endmodule
bind srcc_status srcc_checker chk_u (.clk_in(clk_in), .rst_in(rst_in),
	.cmd_in(cmd_in), .cmd_data_in(cmd_data_in), .pending_in(pending_in),
	.msg_avail_in(msg_avail_in), .resp_valid_out(resp_valid_out),
	.stb_out(stb_out), .err_clear_out(err_clear_out),
	.dflt_load_out(dflt_load_out), .srq_out(srq_out));
